// ===== design/snp_pkg.sv
/*
 Shared constants and types of the serial-to-network packetizer.
 Assumes a single 125 MHz clock and configuration held stable by
 the surroundings while frames are being built.
*/
package snp_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int BUF_BYTES         = 1024;
    localparam int CNT_W             = 11;
    localparam int NUM_HOSTS         = 4;
    localparam int CLK_NS            = 8;
    localparam int NS_PER_MS         = 1000000;
    localparam int CYC_PER_MS        = NS_PER_MS / CLK_NS;
    localparam int MS_PER_MIN        = 60000;
    localparam int KEEPALIVE_MS      = 1000;
    localparam int KEEPALIVE_WAIT_MS = 500;
    localparam int TMR_W             = 23;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DLM_PASS,
        DLM_PLUS1,
        DLM_PLUS2,
        DLM_STRIP
    } snp_dlm_mode_t;

    typedef enum logic {
        ST_FILL,
        ST_DRAIN
    } snp_state_t;

    typedef struct packed {
        logic                 dlm1En;
        logic [7:0]           dlm1;
        logic                 dlm2En;
        logic [7:0]           dlm2;
        snp_dlm_mode_t        dlmMode;
        logic [15:0]          forceMs;
        logic [CNT_W-1:0]     packLen;
        logic [15:0]          inactMs;
        logic [6:0]           networkIdleTimeout;
        logic                 clientMode;
        logic                 connectAnyChar;
        logic                 skipStalledHost;
    } snp_cfg_t;

    typedef struct packed {
        logic                 valid;
        logic [7:0]           data;
        logic                 last;
        logic [NUM_HOSTS-1:0] hostMask;
    } snp_tx_t;

endpackage : snp_pkg

// ===== design/snp_packetizer.sv
/*
 Packs serial bytes into network frames and supervises the session.
 Assumes serial bytes arrive as one-cycle strobes synchronous to clk,
 and that network hosts signal readiness per byte on hostReady.
*/
`timescale 1ns/1ps
module snp_packetizer #(
    parameter int CYC_PER_MS = snp_pkg::CYC_PER_MS
) (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire snp_pkg::snp_cfg_t              cfg,
    input  wire logic                           rxValid,
    input  wire logic [7:0]                     rxData,
    input  wire logic                           serTxActive,
    input  wire logic                           sessionConnect,
    input  wire logic                           closeReq,
    input  wire logic                           netActivity,
    input  wire logic                           keepaliveAck,
    input  wire logic [snp_pkg::NUM_HOSTS-1:0]  hostConnected,
    input  wire logic [snp_pkg::NUM_HOSTS-1:0]  hostReady,
    output snp_pkg::snp_tx_t                    tx,
    output logic                                rxReady,
    output logic                                sessionOpen,
    output logic                                sessionDrop,
    output logic                                keepaliveProbe
);
    import snp_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        snp_state_t                 st;
        logic [BUF_BYTES-1:0][7:0]  mem;
        logic [CNT_W-1:0]           cnt;
        logic [CNT_W-1:0]           len;
        logic [CNT_W-1:0]           rd;
        logic                       d1Seen;
        logic                       extraOn;
        logic [1:0]                 extra;
        logic [16:0]                msDiv;
        logic [15:0]                forceMs;
        logic [15:0]                inactMs;
        logic [TMR_W-1:0]           aliveMs;
        logic [15:0]                kaMs;
        logic                       kaWait;
        snp_tx_t                    tx;
        logic                       rxReady;
        logic                       open;
        logic                       drop;
        logic                       probe;
    } snp_regs_t;

    localparam logic [16:0] DIV_LAST = 17'(CYC_PER_MS - 1);
    localparam logic [CNT_W-1:0] BUF_FULL = CNT_W'(BUF_BYTES);

    snp_regs_t s;
    snp_regs_t n;

    // Limit check shared by every millisecond timer
    function automatic logic reached(
        input logic [TMR_W-1:0] cur,
        input logic [TMR_W-1:0] lim
    );
        reached = (cur + 23'd1) >= lim;
    endfunction : reached

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic             tick;
        logic             m1;
        logic             hit;
        logic             strip;
        logic             rel;
        logic [CNT_W-1:0] wcnt;
        logic             serAct;
        logic             inactEn;
        logic             close;
        logic             go;
        logic [TMR_W-1:0] aliveLim;
        tick     = (s.msDiv == DIV_LAST);
        m1       = 1'b0;
        hit      = 1'b0;
        strip    = 1'b0;
        rel      = 1'b0;
        wcnt     = s.cnt;
        serAct   = rxValid | serTxActive;
        inactEn  = 1'b0;
        close    = 1'b0;
        go       = 1'b0;
        aliveLim = TMR_W'(cfg.networkIdleTimeout) * TMR_W'(MS_PER_MIN);
        n        = s;
        n.drop   = 1'b0;
        n.probe  = 1'b0;
        n.msDiv  = tick ? 17'h0_0000 : s.msDiv + 17'h0_0001;

        // Frame building and release
        case (s.st)
            ST_FILL: begin
                if (rxValid && s.rxReady) begin
                    m1  = cfg.dlm1En && (rxData == cfg.dlm1);
                    // Without the first delimiter nothing matches
                    hit = cfg.dlm1En && (cfg.dlm2En ?
                          (s.d1Seen && rxData == cfg.dlm2) : m1);
                    n.d1Seen = cfg.dlm2En && m1;
                    strip = hit && (cfg.dlmMode == DLM_STRIP);
                    if (!strip) begin
                        n.mem[s.cnt[9:0]] = rxData;
                        wcnt = s.cnt + 11'h001;
                    end else if (cfg.dlm2En && s.cnt != 11'h000) begin
                        // Drop the first delimiter already stored
                        wcnt = s.cnt - 11'h001;
                    end
                    if (s.extraOn) begin
                        n.extra = s.extra - 2'h1;
                        if (s.extra == 2'h1) begin
                            rel = 1'b1;
                        end
                    end else if (hit) begin
                        case (cfg.dlmMode)
                            DLM_PLUS1: begin
                                n.extraOn = 1'b1;
                                n.extra   = 2'h1;
                            end
                            DLM_PLUS2: begin
                                n.extraOn = 1'b1;
                                n.extra   = 2'h2;
                            end
                            // Pass keeps the delimiter, strip drops it
                            default: rel = 1'b1;
                        endcase
                    end
                    if (wcnt == BUF_FULL) begin
                        rel = 1'b1;
                    end
                    if (cfg.packLen != 11'h000 && wcnt == cfg.packLen) begin
                        rel = 1'b1;
                    end
                    n.cnt = wcnt;
                end
                // Interval counts from the first byte held
                if (cfg.forceMs != 16'h0000 && s.cnt != 11'h000
                        && tick) begin
                    n.forceMs = s.forceMs + 16'h0001;
                    if (reached(TMR_W'(s.forceMs), TMR_W'(cfg.forceMs)))
                    begin
                        rel = 1'b1;
                    end
                end
                if (rel) begin
                    n.cnt     = '0;
                    n.forceMs = '0;
                    n.extraOn = 1'b0;
                    n.extra   = 2'h0;
                    n.d1Seen  = 1'b0;
                    // An all-stripped frame has nothing to send
                    if (wcnt != 11'h000) begin
                        n.st      = ST_DRAIN;
                        n.len     = wcnt;
                        n.rd      = '0;
                        n.rxReady = 1'b0;
                    end
                end
            end
            ST_DRAIN: begin
                // Stalled hosts are dropped or waited for
                go = cfg.skipStalledHost ?
                     (|(hostConnected & hostReady) || hostConnected == '0)
                     : &(hostReady | ~hostConnected);
                if (!s.tx.valid || go) begin
                    if (s.rd < s.len) begin
                        n.tx.valid    = 1'b1;
                        n.tx.data     = s.mem[s.rd[9:0]];
                        n.tx.last     = (s.rd == s.len - 11'h001);
                        n.tx.hostMask = cfg.skipStalledHost ?
                                        hostConnected & hostReady :
                                        hostConnected;
                        n.rd          = s.rd + 11'h001;
                    end else begin
                        n.tx      = '0;
                        n.st      = ST_FILL;
                        n.rxReady = 1'b1;
                    end
                end
            end
            default: begin
                n.st      = ST_FILL;
                n.rxReady = 1'b1;
            end
        endcase

        // Serial inactivity, both directions reset it
        inactEn = cfg.inactMs != 16'h0000 &&
                  (!cfg.clientMode || cfg.connectAnyChar);
        if (serAct || !s.open) begin
            n.inactMs = '0;
        end else if (tick) begin
            n.inactMs = s.inactMs + 16'h0001;
            if (inactEn &&
                    reached(TMR_W'(s.inactMs), TMR_W'(cfg.inactMs))) begin
                close = 1'b1;
            end
        end

        // Network idle supervision in minutes
        if (netActivity || !s.open) begin
            n.aliveMs = '0;
        end else if (tick) begin
            n.aliveMs = s.aliveMs + 23'h00_0001;
            if (cfg.networkIdleTimeout != 7'h00 &&
                    reached(s.aliveMs, aliveLim)) begin
                close = 1'b1;
            end
        end

        // Keep-alive only runs with inactivity disabled
        if (!s.open || cfg.inactMs != 16'h0000) begin
            n.kaMs   = '0;
            n.kaWait = 1'b0;
        end else if (s.kaWait && keepaliveAck) begin
            n.kaMs   = '0;
            n.kaWait = 1'b0;
        end else if (tick) begin
            n.kaMs = s.kaMs + 16'h0001;
            if (!s.kaWait &&
                    reached(TMR_W'(s.kaMs), TMR_W'(KEEPALIVE_MS))) begin
                n.probe  = 1'b1;
                n.kaWait = 1'b1;
                n.kaMs   = '0;
            end else if (s.kaWait &&
                    reached(TMR_W'(s.kaMs), TMR_W'(KEEPALIVE_WAIT_MS))) begin
                close = 1'b1;
            end
        end

        // Closing beats a connect in the same cycle
        if (closeReq) begin
            close = 1'b1;
        end
        if (close && s.open) begin
            n.open   = 1'b0;
            n.drop   = 1'b1;
            n.kaWait = 1'b0;
            n.kaMs   = '0;
        end else if (sessionConnect) begin
            n.open = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s         <= '0;
            s.rxReady <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign tx             = s.tx;
    assign rxReady        = s.rxReady;
    assign sessionOpen    = s.open;
    assign sessionDrop    = s.drop;
    assign keepaliveProbe = s.probe;

endmodule : snp_packetizer

// ===== tb/snp_packetizer_sva.sv
/* Concurrent checks on the packetizer ports.
   Bound to snp_packetizer; sees nothing but its ports. */
`timescale 1ns/1ps
module snp_packetizer_sva #(
    parameter int CYC_PER_MS = snp_pkg::CYC_PER_MS
) (
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire snp_pkg::snp_cfg_t             cfg,
    input wire logic                          rxValid,
    input wire logic [7:0]                    rxData,
    input wire logic                          serTxActive,
    input wire logic                          sessionConnect,
    input wire logic                          closeReq,
    input wire logic                          netActivity,
    input wire logic                          keepaliveAck,
    input wire logic [snp_pkg::NUM_HOSTS-1:0] hostConnected,
    input wire logic [snp_pkg::NUM_HOSTS-1:0] hostReady,
    input wire snp_pkg::snp_tx_t              tx,
    input wire logic                          rxReady,
    input wire logic                          sessionOpen,
    input wire logic                          sessionDrop,
    input wire logic                          keepaliveProbe
);
    import snp_pkg::*;
    // Byte is taken when the hosts the skip option cares for are ready
    wire logic go = cfg.skipStalledHost
        ? (|(hostConnected & hostReady) || hostConnected == '0)
        : ((hostConnected & hostReady) == hostConnected);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Frame output
    // ------------------------------------------------------------
    AST_TX_HOLD: assert property (
        tx.valid && !go |=> tx.valid && $stable(tx.data))
        else $error("byte moved before it was taken");
    AST_MASK_ALL: assert property (
        tx.valid && !cfg.skipStalledHost |-> tx.hostMask == hostConnected)
        else $error("frame not aimed at every host");
    AST_MASK_SKIP: assert property (
        tx.valid |-> (tx.hostMask & ~hostConnected) == '0)
        else $error("frame aimed at an absent host");
    AST_DRAIN_BLOCK: assert property (
        tx.valid |-> !rxReady)
        else $error("bytes accepted while draining");
    AST_DLM_PASS: assert property (
        rxValid && rxReady && cfg.dlm1En && !cfg.dlm2En &&
        cfg.dlmMode == DLM_PASS && rxData == cfg.dlm1 |-> ##2 tx.valid)
        else $error("lone delimiter did not release");
    AST_LAST_END: assert property (
        tx.valid && tx.last && go |=> !tx.valid)
        else $error("output ran past frame end");
    // ------------------------------------------------------------
    // Session
    // ------------------------------------------------------------
    AST_CLOSE: assert property (
        closeReq && sessionOpen |=>
        !sessionOpen && sessionDrop ##1 !sessionDrop)
        else $error("close request not honoured");
    AST_CLIENT_HOLD: assert property (
        sessionOpen && cfg.clientMode && !cfg.connectAnyChar &&
        cfg.inactMs != '0 && cfg.networkIdleTimeout == '0 &&
        !closeReq |=> sessionOpen)
        else $error("client session closed by inactivity");
    AST_PROBE_PULSE: assert property (
        keepaliveProbe |=> !keepaliveProbe)
        else $error("probe longer than one cycle");
    CV_FRAME: cover property (tx.valid && tx.last && go);
    CV_STALL: cover property (tx.valid && !go);
    CV_DROP: cover property (sessionDrop);
endmodule : snp_packetizer_sva

bind snp_packetizer snp_packetizer_sva #(.CYC_PER_MS(CYC_PER_MS)) sva_u (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .rxValid(rxValid),
    .rxData(rxData), .serTxActive(serTxActive),
    .sessionConnect(sessionConnect), .closeReq(closeReq),
    .netActivity(netActivity), .keepaliveAck(keepaliveAck),
    .hostConnected(hostConnected), .hostReady(hostReady), .tx(tx),
    .rxReady(rxReady), .sessionOpen(sessionOpen),
    .sessionDrop(sessionDrop), .keepaliveProbe(keepaliveProbe));

// ===== tb/snp_serial_dev.sv
/* Serial device model feeding byte strobes.
   Assumes the caller paces it from the falling clock edge. */
`timescale 1ns/1ps
module snp_serial_dev (
    input  wire logic clk,
    input  wire logic rxReady,
    output logic      rxValid,
    output logic [7:0] rxData
);
    initial begin
        rxValid = 1'b0;
        rxData  = 8'hA5;
    end
    // Back to back bytes keep a series inside one interval
    task automatic sendByte(input logic [7:0] b);
        @(negedge clk);
        while (!rxReady) begin
            rxValid = 1'b0;
            @(negedge clk);
        end
        rxValid = 1'b1;
        rxData  = b;
    endtask : sendByte
    // Released line shows the inverse so stale data never matches
    task automatic idle();
        @(negedge clk);
        rxValid = 1'b0;
        rxData  = ~rxData;
    endtask : idle
endmodule : snp_serial_dev

// ===== tb/snp_packetizer_bench.sv
/* Self-checking bench of the packetizer.
   Assumes the serial device model and the bound checker. */
`timescale 1ns/1ps
module snp_packetizer_bench;
    import snp_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    snp_cfg_t   cfg = '0;
    logic       sessionConnect = 1'b0, closeReq = 1'b0;
    logic       keepaliveAck = 1'b0, serTxActive = 1'b0;
    logic       netActivity = 1'b0;
    logic [3:0] hostConnected = 4'h1, hostReady = 4'hF, lastMask;
    logic       rxValid, rxReady, sessionOpen, sessionDrop;
    logic       keepaliveProbe;
    logic [7:0] rxData, got[$], big[$];
    snp_tx_t    tx;
    int         failCount = 0, nTests = 0, cycles = 0, waited, d0, p0;
    int         frames = 0, drops = 0, probes = 0;
    wire logic go = cfg.skipStalledHost
        ? (|(hostConnected & hostReady) || hostConnected == 4'h0)
        : ((hostConnected & hostReady) == hostConnected);

    always #4 clk = ~clk;
    snp_serial_dev ser_u (.clk(clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData));
    snp_packetizer #(.CYC_PER_MS(4)) dut_u (
        .clk(clk), .rst_n(rst_n), .cfg(cfg), .rxValid(rxValid),
        .rxData(rxData), .serTxActive(serTxActive),
        .sessionConnect(sessionConnect), .closeReq(closeReq),
        .netActivity(netActivity), .keepaliveAck(keepaliveAck),
        .hostConnected(hostConnected), .hostReady(hostReady), .tx(tx),
        .rxReady(rxReady), .sessionOpen(sessionOpen),
        .sessionDrop(sessionDrop), .keepaliveProbe(keepaliveProbe));
    // Collect taken bytes and events; a hung run ends itself
    always @(posedge clk) begin
        cycles++;
        if (tx.valid && go) begin
            got.push_back(tx.data);
            lastMask = tx.hostMask;
            if (tx.last) frames++;
        end
        if (sessionDrop) drops++;
        if (keepaliveProbe) probes++;
        if (cycles == 40000) begin
            failCount++;
            endOfTest();
        end
    end
    task automatic chk(input string w, input logic [31:0] e, s);
        nTests++;
        if (e !== s) begin
            failCount++;
            $display("mismatch %s expected %0h seen %0h", w, e, s);
        end
    endtask : chk
    // Send bytes, wait for one frame, compare it whole
    task automatic runFrame(input logic [7:0] s[$], e[$]);
        int f0;
        f0 = frames;
        got.delete();
        foreach (s[k]) ser_u.sendByte(s[k]);
        ser_u.idle();
        waited = 0;
        while (frames == f0 && waited < 3000) begin
            @(negedge clk);
            waited++;
        end
        chk("frameLen", e.size(), got.size());
        foreach (e[k]) chk("frameByte", e[k], got[k]);
    endtask : runFrame
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : endOfTest
    // Main sequence: delimiters, lengths, timers, hosts, session
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("rxReady", 1, rxReady);
        chk("txValid", 0, tx.valid);
        cfg.dlm1En = 1'b1;
        cfg.dlm1 = 8'h0D;
        runFrame({8'h41, 8'h0D}, {8'h41, 8'h0D});
        cfg.dlmMode = DLM_PLUS1;
        runFrame({8'h11, 8'h0D, 8'h22}, {8'h11, 8'h0D, 8'h22});
        cfg.dlmMode = DLM_PLUS2;
        big = {8'h11, 8'h0D, 8'h0D, 8'h33};
        runFrame(big, big);
        cfg.dlmMode = DLM_STRIP;
        runFrame({8'h11, 8'h0D}, {8'h11});
        cfg.dlm2En = 1'b1;
        cfg.dlm2 = 8'h0A;
        runFrame({8'h11, 8'h0D, 8'h0A}, {8'h11});
        cfg.dlmMode = DLM_PASS;
        big = {8'h0D, 8'h33, 8'h0D, 8'h0A};
        runFrame(big, big);
        cfg.dlm1En = 1'b0;
        cfg.packLen = 11'h003;
        d0 = frames;
        ser_u.sendByte(8'h0D);
        ser_u.sendByte(8'h0A);
        ser_u.idle();
        repeat (60) @(negedge clk);
        chk("noRelease", d0, frames);
        runFrame({8'h55}, {8'h0D, 8'h0A, 8'h55});
        cfg.dlm2En = 1'b0;
        cfg.packLen = 11'h000;
        big.delete();
        for (int i = 0; i < 1024; i++) big.push_back(i[7:0]);
        runFrame(big, big);
        cfg.forceMs = 16'h0003; // Far longer than one byte time
        runFrame({8'h01, 8'h02}, {8'h01, 8'h02});
        chk("forceWait", 1, waited > 4 && waited <= 20);
        cfg.forceMs = 16'h0000;
        cfg.dlm1En = 1'b1;
        hostConnected = 4'h3;
        hostReady = 4'h1;
        fork
            runFrame({8'h0D}, {8'h0D});
            begin
                repeat (30) @(negedge clk);
                chk("stall", 1, tx.valid);
                hostReady = 4'h3;
            end
        join
        chk("maskAll", 4'h3, lastMask);
        cfg.skipStalledHost = 1'b1;
        hostReady = 4'h1;
        runFrame({8'h0D}, {8'h0D});
        chk("maskSkip", 4'h1, lastMask);
        cfg.inactMs = 16'h0005; // Kept above the force interval
        pulse(sessionConnect);
        d0 = drops;
        repeat (40) @(negedge clk);
        chk("inactDrop", d0 + 1, drops);
        cfg.clientMode = 1'b1;
        pulse(sessionConnect);
        repeat (60) @(negedge clk);
        chk("clientHold", 1, sessionOpen);
        cfg.connectAnyChar = 1'b1;
        repeat (40) @(negedge clk);
        chk("clientDrop", 0, sessionOpen);
        cfg.inactMs = 16'h0000;
        pulse(sessionConnect);
        d0 = drops;
        p0 = probes;
        repeat (4100) @(negedge clk);
        chk("probe", p0 + 1, probes);
        pulse(keepaliveAck);
        repeat (2100) @(negedge clk);
        chk("ackHold", d0, drops);
        repeat (4200) @(negedge clk);
        chk("ackMiss", d0 + 1, drops);
        pulse(sessionConnect);
        pulse(closeReq);
        chk("closeDrop", 1, sessionDrop);
        chk("closed", 0, sessionOpen);
        endOfTest();
    end
endmodule : snp_packetizer_bench
